// [rtl/fwsc_top.sv]
`timescale 1ns/100ps
`include "fwsc_regs.svh"
module fwsc_top #(
	parameter int SETTLE_CYC = `FWSC_SETTLE_CYC,
	parameter int SETUP_CYC  = `FWSC_SETUP_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// device pins
	output logic             ce_n,
	output logic             oe_n,
	output logic             we_n,
	output logic [16:0]      addr_pin,
	output logic [7:0]       data_out,
	output logic             data_oe,
	input  wire logic [7:0]  flash_data_pin,
	output logic             program_enable_pin,
	output logic             dev_reset_n
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		fwsc_pkg::fwsc_state_e st;
		logic [3:0]            cnt;
		logic [1:0]            op;
		logic                  ready;
		logic                  pen;
		logic                  boot;
		logic                  rst;
		logic                  rst_n;
		logic                  bits_set;
		logic [16:0]           addr;
		logic [7:0]            wdata;
		fwsc_pkg::fwsc_byte_t  rdata;
		logic                  busy;
		logic                  refused;
		logic [31:0]           prdata;
		logic                  pslverr;
		logic                  ce_n;
		logic                  oe_n;
		logic                  we_n;
		logic                  doe;
	} fwsc_s;
	fwsc_s s_reg;
	fwsc_s s_next;
	logic        wr_ctrl;
	logic        wr_cmd;
	logic        wr_addr;
	logic        wr_wdata;
	logic        rd_hit;
	logic [2:0]  rd_sel;
	logic        settle_done;
	logic        setup_done;
	logic        settle_seen_reg;
	logic        timer_go_reg;
	logic        pready_reg;
	logic        first_acc;
	logic        do_ctrl;
	logic        do_cmd;
	logic        do_addr;
	logic        do_wdata;
	logic        addr_misaligned;
	// ****************************************
	// apb bus address decode
	// ****************************************
	fwsc_apb u_apb (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.wr_ctrl  (wr_ctrl),
		.wr_cmd   (wr_cmd),
		.wr_addr  (wr_addr),
		.wr_wdata (wr_wdata),
		.rd_hit   (rd_hit),
		.rd_sel   (rd_sel)
	);
	// ****************************************
	// register strobes
	// ****************************************
	// effects land in the first access cycle, so the registered
	// answer already stands when pready is sampled high
	// the second access cycle only carries the answer
	assign first_acc = psel && penable && !pready_reg;
	assign do_ctrl   = wr_ctrl && !pready_reg;
	assign do_cmd    = wr_cmd && !pready_reg;
	assign do_addr   = wr_addr && !pready_reg;
	assign do_wdata  = wr_wdata && !pready_reg;
	// program transfers want low byte 00 or 80; others still go out
	assign addr_misaligned = s_reg.addr[6:0] != 7'h00;
	// ****************************************
	// power-up timers
	// ****************************************
	// settle then setup chained on one timer each
	fwsc_timer #(.W(32)) u_settle (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (timer_go_reg),
		.load    (SETTLE_CYC[31:0]),
		.done    (settle_done)
	);
	fwsc_timer #(.W(32)) u_setup (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (settle_done),
		.load    (SETUP_CYC[31:0]),
		.done    (setup_done)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_go_reg    <= 1'b1;
			settle_seen_reg <= 1'b0;
		end else begin
			timer_go_reg <= 1'b0;
			if (settle_done)
				settle_seen_reg <= 1'b1;
		end
	end
	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.prdata  = `FWSC_RESET_VAL;
		s_next.pslverr = 1'b0;
		// settle then setup; afterwards device is in memory read mode
		if (setup_done)
			s_next.ready = 1'b1;
		if (do_ctrl) begin
			s_next.boot = pwdata[`FWSC_CTRL_BOOT_BIT];
			s_next.rst  = pwdata[`FWSC_CTRL_RST_BIT];
			s_next.rst_n = !pwdata[`FWSC_CTRL_RST_BIT];
			s_next.bits_set = pwdata[`FWSC_CTRL_BITS_BIT];
			// enable only after settle; in boot mode only under reset
			if ((!s_reg.boot || s_reg.rst) && settle_seen_reg) begin
				// interrupts and watchdog stay with software while high
				if (pwdata[`FWSC_CTRL_PEN_BIT])
					s_next.pen = 1'b1;
				else if (!pwdata[`FWSC_CTRL_BITS_BIT])
					s_next.pen = 1'b0;
			end
		end
		// address passed on as written; the device flags a bad one
		if (do_addr)
			s_next.addr = pwdata[16:0];
		if (do_wdata)
			s_next.wdata = pwdata[7:0];
		// command writes refused until ready or while busy
		// erase before program and one program per block: software
		if (do_cmd) begin
			if (!s_reg.ready || s_reg.busy) begin
				s_next.refused = 1'b1;
				s_next.pslverr = 1'b1;
			end else begin
				s_next.busy    = 1'b1;
				s_next.refused = 1'b0;
				s_next.op      = pwdata[1:0];
			end
		end
		if (first_acc && !pwrite) begin
			case (rd_sel)
				3'h0: s_next.prdata = {28'h0, s_reg.bits_set, s_reg.rst,
					s_reg.boot, s_reg.pen};
				3'h1: s_next.prdata = {28'h0, addr_misaligned,
					s_reg.refused, s_reg.ready, s_reg.busy};
				3'h2: s_next.prdata = {15'h0, s_reg.addr};
				// undefined status bits 2 and 3 read back as zero
				// kept for software after an end and before power-off
				3'h3: s_next.prdata = {24'h0,
					s_reg.rdata & `FWSC_ST_DEFMASK};
				3'h4: s_next.prdata = {24'h0, s_reg.rdata};
				3'h5: s_next.prdata = {24'h0, s_reg.wdata};
				default: s_next.prdata = `FWSC_RESET_VAL;
			endcase
			s_next.pslverr = !rd_hit;
		end else if (first_acc && !(do_ctrl || do_cmd || do_addr
			|| do_wdata)) begin
			s_next.pslverr = 1'b1;
		end
		case (s_reg.st)
			fwsc_pkg::FWSC_IDLE: begin
				if (s_next.busy && !s_reg.busy)
					s_next.st = fwsc_pkg::FWSC_SETUP;
			end
			fwsc_pkg::FWSC_SETUP: begin
				s_next.ce_n = 1'b0;
				s_next.cnt  = 4'h0;
				if (s_reg.op == `FWSC_CMD_READ) begin
					s_next.oe_n = 1'b0;
				end else begin
					s_next.we_n = 1'b0;
					s_next.doe  = 1'b1;
				end
				s_next.st = fwsc_pkg::FWSC_STRB;
			end
			fwsc_pkg::FWSC_STRB: begin
				s_next.cnt = s_reg.cnt + 4'h1;
				if (s_reg.cnt == 4'(`FWSC_PULSE_CYC - 1))
					s_next.st = fwsc_pkg::FWSC_LATCH;
			end
			fwsc_pkg::FWSC_LATCH: begin
				// polling and status held by device on data pins
				if (s_reg.op == `FWSC_CMD_READ)
					s_next.rdata = flash_data_pin;
				s_next.we_n = 1'b1;
				s_next.oe_n = 1'b1;
				s_next.st   = fwsc_pkg::FWSC_HOLD;
			end
			fwsc_pkg::FWSC_HOLD: begin
				// data held past we rise for hold time
				s_next.doe  = 1'b0;
				s_next.ce_n = 1'b1;
				s_next.cnt  = 4'h0;
				s_next.st   = fwsc_pkg::FWSC_GAP;
			end
			fwsc_pkg::FWSC_GAP: begin
				s_next.cnt = s_reg.cnt + 4'h1;
				if (s_reg.cnt == 4'(`FWSC_PULSE_CYC - 1)) begin
					s_next.busy = 1'b0;
					s_next.st   = fwsc_pkg::FWSC_IDLE;
				end
			end
			default: s_next.st = fwsc_pkg::FWSC_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{st: fwsc_pkg::FWSC_IDLE, cnt: 4'h0, op: 2'h0,
				ready: 1'b0, pen: 1'b0, boot: 1'b0, rst: 1'b0, rst_n: 1'b1,
				bits_set: 1'b0, addr: 17'h0, wdata: 8'h00,
				rdata: 8'h00, busy: 1'b0, refused: 1'b0,
				prdata: 32'h0, pslverr: 1'b0, ce_n: 1'b1,
				oe_n: 1'b1, we_n: 1'b1, doe: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	// pen low from reset: supply assumed unstable until settle
	assign program_enable_pin = s_reg.pen;
	assign dev_reset_n = s_reg.rst_n;
	assign ce_n     = s_reg.ce_n;
	assign oe_n     = s_reg.oe_n;
	assign we_n     = s_reg.we_n;
	assign addr_pin = s_reg.addr;
	assign data_out = s_reg.wdata;
	assign data_oe  = s_reg.doe;
	assign prdata   = s_reg.prdata;
	assign pslverr  = s_reg.pslverr;
	// ****************************************
	// apb response
	// ****************************************
	// one wait state: answer is registered from the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready_reg <= 1'b0;
		else
			pready_reg <= first_acc;
	end
	assign pready = pready_reg;
endmodule // fwsc_top

// [rtl/fwsc_regs.svh]
`ifndef FWSC_REGS_SVH
`define FWSC_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define FWSC_CTRL_OFF     12'h000
`define FWSC_CMD_OFF      12'h004
`define FWSC_ADDR_OFF     12'h008
`define FWSC_STAT_OFF     12'h00c
`define FWSC_RDATA_OFF    12'h010
`define FWSC_WDATA_OFF    12'h014
// ****************************************
// control fields
// ****************************************
`define FWSC_CTRL_PEN_BIT   0
`define FWSC_CTRL_BOOT_BIT  1
`define FWSC_CTRL_RST_BIT   2
`define FWSC_CTRL_BITS_BIT  3
// ****************************************
// command codes
// ****************************************
`define FWSC_CMD_WRITE    2'h0
`define FWSC_CMD_READ     2'h1
`define FWSC_CMD_SEQ      2'h2
// ****************************************
// status read byte fields
// ****************************************
`define FWSC_ST_ABN       7
`define FWSC_ST_CMDERR    6
`define FWSC_ST_PRGERR    5
`define FWSC_ST_ERSERR    4
`define FWSC_ST_CNTEXC    1
`define FWSC_ST_ADRERR    0
`define FWSC_ST_DEFMASK   8'hf3
// ****************************************
// timing
// ****************************************
`define FWSC_CLK_MHZ      100
`define FWSC_SETTLE_MS    10
`define FWSC_SETUP_MS     10
`define FWSC_SETTLE_CYC   (`FWSC_SETTLE_MS*1000*`FWSC_CLK_MHZ)
`define FWSC_SETUP_CYC    (`FWSC_SETUP_MS*1000*`FWSC_CLK_MHZ)
`define FWSC_CYC_NS       10
`define FWSC_PULSE_NS     100
`define FWSC_PULSE_CYC    ((`FWSC_PULSE_NS+`FWSC_CYC_NS-1)/`FWSC_CYC_NS)
`define FWSC_RESET_VAL    32'h0000_0000
`endif

// [rtl/fwsc_pkg.sv]
package fwsc_pkg;
	typedef enum logic [5:0] {
		FWSC_IDLE  = 6'h01,
		FWSC_SETUP = 6'h02,
		FWSC_STRB  = 6'h04,
		FWSC_HOLD  = 6'h08,
		FWSC_LATCH = 6'h10,
		FWSC_GAP   = 6'h20
	} fwsc_state_e;
	typedef logic [7:0] fwsc_byte_t;
endpackage

// [rtl/fwsc_timer.sv]
`timescale 1ns/100ps
`include "fwsc_regs.svh"
module fwsc_timer #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	// result
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic         done_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= '0;
			done_reg <= 1'b0;
		end else if (start) begin
			cnt_reg  <= load;
			done_reg <= 1'b0;
		end else if (cnt_reg != '0) begin
			cnt_reg  <= cnt_reg - 1'b1;
			done_reg <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
		end else begin
			// one-cycle pulse so a chained timer starts only once
			done_reg <= 1'b0;
		end
	end
	assign done = done_reg;
endmodule // fwsc_timer

// [rtl/fwsc_apb.sv]
`timescale 1ns/100ps
`include "fwsc_regs.svh"
module fwsc_apb (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	// decoded strobes
	output logic             wr_ctrl,
	output logic             wr_cmd,
	output logic             wr_addr,
	output logic             wr_wdata,
	output logic             rd_hit,
	output logic [2:0]       rd_sel
);
	logic acc;
	assign acc      = psel && penable;
	assign wr_ctrl  = acc && pwrite && paddr == `FWSC_CTRL_OFF;
	assign wr_cmd   = acc && pwrite && paddr == `FWSC_CMD_OFF;
	assign wr_addr  = acc && pwrite && paddr == `FWSC_ADDR_OFF;
	assign wr_wdata = acc && pwrite && paddr == `FWSC_WDATA_OFF;
	always_comb begin
		rd_hit = 1'b1;
		rd_sel = 3'h7;
		case (paddr)
			`FWSC_CTRL_OFF:  rd_sel = 3'h0;
			`FWSC_CMD_OFF:   rd_sel = 3'h1;
			`FWSC_ADDR_OFF:  rd_sel = 3'h2;
			`FWSC_STAT_OFF:  rd_sel = 3'h3;
			`FWSC_RDATA_OFF: rd_sel = 3'h4;
			`FWSC_WDATA_OFF: rd_sel = 3'h5;
			default:         rd_hit = 1'b0;
		endcase
	end
endmodule // fwsc_apb

// [verification/fwsc_flash_model.sv]
`timescale 1ns/100ps
// ****************************************
// device side model
// ****************************************
module fwsc_flash_model #(
	parameter logic [7:0] CMD_STAT  = 8'h71,
	parameter logic [7:0] CMD_PROG  = 8'h40,
	parameter logic [7:0] STAT_CODE = 8'h81
) (
	// clock
	input  wire logic        pclk,
	// device pins
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [16:0] addr_pin,
	input  wire logic [7:0]  data_out,
	output logic [7:0]       flash_data_pin
);
	logic [1:0] mode;
	logic [7:0] last;
	logic [7:0] q;
	logic [1:0] tog;
	initial mode = 2'h0;
	initial last = 8'h00;
	initial tog = 2'h0;
	// mode only moves on a command write
	always @(posedge we_n) begin
		if (!ce_n) begin
			// erase is whole-array only and not modelled
			mode <= (data_out == CMD_STAT) ? 2'h1 :
				(data_out == CMD_PROG) ? 2'h2 : 2'h0;
		end
	end
	always_comb begin
		case (mode)
			2'h1: q = (STAT_CODE & 8'hf3) | {4'h0, tog, 2'h0};
			2'h2: q = 8'hc0;
			default: q = addr_pin[7:0];
		endcase
	end
	// released bus shows the inverse, not a stale value
	always @(posedge pclk) begin
		tog <= tog + 2'h1;
		if (!ce_n && !oe_n) begin
			last <= q;
		end
	end
	assign flash_data_pin = (!ce_n && !oe_n) ? q : ~last;
endmodule // fwsc_flash_model

// [verification/fwsc_monitor.sv]
`timescale 1ns/100ps
module fwsc_monitor #(
	parameter int SETTLE_CYC = 20,
	parameter int SETUP_CYC  = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// device pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic data_oe,
	input wire logic program_enable_pin
);
	int cnt_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 0;
		end else if (cnt_reg < SETTLE_CYC + SETUP_CYC) begin
			cnt_reg <= cnt_reg + 1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_rw_exclusive: assert property (!(!oe_n && !we_n))
		else $error("read and write strobes together");
	chk_drive_write: assert property (!we_n |-> data_oe && !ce_n)
		else $error("write strobe without driven data");
	chk_no_fight: assert property (!oe_n |-> !data_oe)
		else $error("data driven during read");
	chk_ready_timing: assert property (psel && !penable |=>
		!pready ##1 pready)
		else $error("ready not on third cycle");
	chk_pen_settle: assert property (cnt_reg < SETTLE_CYC |->
		!program_enable_pin)
		else $error("enable raised before settle");
	chk_cmd_lockout: assert property (cnt_reg < SETTLE_CYC + SETUP_CYC |->
		we_n && oe_n)
		else $error("device strobed during setup");
	chk_cmd_gap: assert property ($rose(ce_n) |-> ce_n [*8])
		else $error("commands too close");
	chk_pulse_width: assert property ($fell(we_n) |-> !we_n [*8])
		else $error("write pulse too short");
endmodule // fwsc_monitor
bind fwsc_top fwsc_monitor #(.SETTLE_CYC(SETTLE_CYC), .SETUP_CYC(SETUP_CYC))
	mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
	.data_oe(data_oe), .program_enable_pin(program_enable_pin));

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
	typedef struct {logic [7:0] a; logic [1:0] op; logic [7:0] wd;
		logic [7:0] ex;} fwsc_row_s;
	localparam logic [7:0] CST = 8'h71;
	localparam logic [7:0] CPG = 8'h40;
	localparam logic [7:0] STV = 8'h81;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, ce_n, oe_n, we_n, data_oe, pen;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [16:0] addr_pin;
	logic [7:0] data_out, fdp;
	logic e, drst;
	int n_fail = 0, samples_checked = 0;
	fwsc_row_s rows [8] = '{'{8'h11, 2'h1, 8'h00, 8'h11},
		'{8'h22, 2'h1, 8'h00, 8'h22}, '{8'h00, 2'h0, CST, 8'h00},
		'{8'h30, 2'h1, 8'h00, STV}, '{8'h40, 2'h1, 8'h00, STV},
		'{8'h00, 2'h0, CPG, 8'h00}, '{8'h01, 2'h1, 8'h00, 8'hc0},
		'{8'h00, 2'h0, 8'hff, 8'h00}};
	fwsc_top #(.SETTLE_CYC(20), .SETUP_CYC(20)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr_pin(addr_pin), .data_out(data_out), .data_oe(data_oe),
		.flash_data_pin(fdp), .program_enable_pin(pen), .dev_reset_n(drst));
	fwsc_flash_model #(.CMD_STAT(CST), .CMD_PROG(CPG), .STAT_CODE(STV))
		dev (.pclk(pclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.addr_pin(addr_pin), .data_out(data_out), .flash_data_pin(fdp));
	initial forever #5 pclk = ~pclk;
	task automatic end_of_test;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("FAIL %0t value %h expected %h", $time, g, x);
		end
	endtask
	task automatic chk1(input logic g, input logic x);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("FAIL %0t bit %b expected %b", $time, g, x);
		end
	endtask
	// one apb transfer, then an idle cycle so strobes never reassign
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
		r = prdata;
		e = pslverr;
		if (k >= 50) begin
			n_fail++;
			$display("FAIL %0t no ready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [1:0] op);
		int k;
		apb(1'b1, 12'h004, {30'h0, op});
		for (k = 0; k < 30; k++) begin
			apb(1'b0, 12'h004, 32'h0);
			if (r[0] === 1'b0) break;
		end
		chk1(r[0], 1'b0);
	endtask
	task automatic ctrl(input logic [3:0] v);
		apb(1'b1, 12'h000, {28'h0, v});
	endtask
	initial begin
		#100us;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge pclk);
		chk1(pen, 1'b0);
		chk1(ce_n, 1'b1);
		presetn <= 1'b1;
		ctrl(4'h1);
		chk1(pen, 1'b0);
		apb(1'b1, 12'h004, 32'h1);
		chk1(e, 1'b1);
		$display("test lockout done");
		repeat (45) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk1(r[1], 1'b1);
		foreach (rows[i]) begin
			apb(1'b1, 12'h008, {24'h0, rows[i].a});
			apb(1'b1, 12'h014, {24'h0, rows[i].wd});
			cmd(rows[i].op);
			if (rows[i].op == 2'h1) begin
				apb(1'b0, 12'h010, 32'h0);
				chk32(r & 32'hf3, {24'h0, rows[i].ex});
				apb(1'b0, 12'h00c, 32'h0);
				chk32(r, {24'h0, rows[i].ex & 8'hf3});
			end
		end
		$display("test rows done");
		apb(1'b0, 12'h004, 32'h0);
		chk1(r[3], 1'b0);
		apb(1'b1, 12'h008, 32'h11);
		apb(1'b0, 12'h004, 32'h0);
		chk1(r[3], 1'b1);
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b1, 12'h004, 32'h1);
		chk1(e, 1'b1);
		repeat (40) @(posedge pclk);
		$display("test busy refuse done");
		ctrl(4'h1);
		chk1(pen, 1'b1);
		ctrl(4'h9);
		ctrl(4'h8);
		chk1(pen, 1'b1);
		ctrl(4'h0);
		chk1(pen, 1'b0);
		ctrl(4'h2);
		ctrl(4'h3);
		chk1(pen, 1'b0);
		ctrl(4'h6);
		ctrl(4'h7);
		chk1(pen, 1'b1);
		chk1(drst, 1'b0);
		$display("test enable done");
		apb(1'b0, 12'h020, 32'h0);
		chk1(e, 1'b1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk1(pen, 1'b0);
		$display("test reset done");
		end_of_test;
	end
endmodule // testbench
